// ===== logic/odl_consts.svh
// Constants for the octal DAC serial loader, both ends
`ifndef ODL_CONSTS_SVH
`define ODL_CONSTS_SVH

// ==================================================
// Word layout
`define ODL_ADDR_W        3
`define ODL_DATA_W        8
`define ODL_NUM_REGS      8
`define ODL_WORD_BITS     5'h0B
`define ODL_LONG_BITS     5'h10
`define ODL_CNT_W         5
`define ODL_SH_W          16
`define ODL_PAD_BITS      5'h00
`define ODL_PRESET_CODE   8'h80

// ==================================================
// Pin vector positions, device side
`define ODL_PIN_W         5
`define ODL_PIN_CS        0
`define ODL_PIN_SCLK      1
`define ODL_PIN_SDI       2
`define ODL_PIN_PD        3
`define ODL_PIN_PRE       4
`define ODL_PIN_IDLE      5'h1B

// ==================================================
// Timing, host side
`define ODL_CLK_MHZ       50
`define ODL_SCLK_HALF_NS  80
`define ODL_SCLK_HALF_CYC ((`ODL_SCLK_HALF_NS * `ODL_CLK_MHZ + 999) / 1000)
`define ODL_HALF_W        4

`endif

// ===== logic/odl_pkg.sv
// Types for both ends of the octal DAC serial loader
package odl_pkg;

    typedef logic [7:0] odl_code_t;

    typedef enum logic [1:0] {
        ODL_D_IDLE  = 2'h1,
        ODL_D_SHIFT = 2'h2
    } odl_dev_state_e;

    typedef enum logic [5:0] {
        ODL_H_IDLE   = 6'h01,
        ODL_H_SELECT = 6'h02,
        ODL_H_LOW    = 6'h04,
        ODL_H_HIGH   = 6'h08,
        ODL_H_HOLD   = 6'h10,
        ODL_H_GAP    = 6'h20
    } odl_host_state_e;

endpackage

// ===== logic/odl_if.sv
// Serial link between host controller and octal DAC loader
`timescale 1ns/1ps

interface odl_if;

    logic cs_n;
    logic sclk;
    logic serial_in;
    logic power_down_n;
    logic preset_n;

    modport host
    (
        output cs_n,
        output sclk,
        output serial_in,
        output power_down_n,
        output preset_n
    );

    modport device
    (
        input  cs_n,
        input  sclk,
        input  serial_in,
        input  power_down_n,
        input  preset_n
    );

endinterface

// ===== logic/odl_dev.sv
// Device end: serial loader and eight 8-bit DAC code registers
`timescale 1ns/1ps
`include "odl_consts.svh"

module odl_dev
    import odl_pkg::*;
#(
    parameter bit HAS_PRESET = 1'b1
)
(
    input  wire logic                                     REF_CLK_I,
    input  wire logic                                     SRST_I,
    odl_if.device                                         LNK,
    output logic [`ODL_NUM_REGS*`ODL_DATA_W-1:0]          CODES_O,
    output logic                                          LOAD_STB_O,
    output logic [`ODL_ADDR_W-1:0]                        LOAD_ADDR_O,
    output logic                                          POWER_DOWN_O,
    output logic                                          SHORT_FRAME_O
);

    // ==================================================
    // Pin synchronisers and agreement filter
    logic [`ODL_PIN_W-1:0] pin_raw;
    logic [`ODL_PIN_W-1:0] s1;
    logic [`ODL_PIN_W-1:0] s2;
    logic [`ODL_PIN_W-1:0] s3;
    logic [`ODL_PIN_W-1:0] filt;
    logic [`ODL_PIN_W-1:0] filt_prev;
    logic [`ODL_PIN_W-1:0] next_s1;
    logic [`ODL_PIN_W-1:0] next_s2;
    logic [`ODL_PIN_W-1:0] next_s3;
    logic [`ODL_PIN_W-1:0] next_filt;

    assign pin_raw[`ODL_PIN_CS]   = LNK.cs_n;
    assign pin_raw[`ODL_PIN_SCLK] = LNK.sclk;
    assign pin_raw[`ODL_PIN_SDI]  = LNK.serial_in;
    assign pin_raw[`ODL_PIN_PD]   = LNK.power_down_n;
    assign pin_raw[`ODL_PIN_PRE]  = LNK.preset_n;

    genvar gi;
    generate
        for (gi = 0; gi < `ODL_PIN_W; gi++)
        begin : g_sync
            always_comb
            begin
                next_s1[gi] = pin_raw[gi];
                next_s2[gi] = s1[gi];
                next_s3[gi] = s2[gi];
                // A change counts only once stages two and three agree
                next_filt[gi] = (s2[gi] == s3[gi]) ? s3[gi] : filt[gi];
            end
        end
    endgenerate

    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            s1        <= `ODL_PIN_IDLE;
            s2        <= `ODL_PIN_IDLE;
            s3        <= `ODL_PIN_IDLE;
            filt      <= `ODL_PIN_IDLE;
            filt_prev <= `ODL_PIN_IDLE;
        end
        else
        begin
            s1        <= next_s1;
            s2        <= next_s2;
            s3        <= next_s3;
            filt      <= next_filt;
            filt_prev <= filt;
        end
    end

    // ==================================================
    // Edge and level events on the filtered pins
    logic cs_low;
    logic cs_rise;
    logic sclk_rise;
    logic pd_active;
    logic pre_active;

    assign cs_low     = ~filt[`ODL_PIN_CS];
    assign cs_rise    = filt[`ODL_PIN_CS] & ~filt_prev[`ODL_PIN_CS];
    // Clock idles high, so only rising edges sample data
    assign sclk_rise  = filt[`ODL_PIN_SCLK] & ~filt_prev[`ODL_PIN_SCLK];
    assign pd_active  = ~filt[`ODL_PIN_PD];
    assign pre_active = HAS_PRESET & ~filt[`ODL_PIN_PRE];

    // ==================================================
    // Frame state and serial shift register
    odl_dev_state_e             state;
    odl_dev_state_e             next_state;
    logic [`ODL_WORD_BITS-1:0]  shreg;
    logic [`ODL_WORD_BITS-1:0]  next_shreg;
    logic [`ODL_CNT_W-1:0]      bit_cnt;
    logic [`ODL_CNT_W-1:0]      next_bit_cnt;
    logic                       do_load;
    logic                       short_frame;

    always_comb
    begin
        next_state   = state;
        next_shreg   = shreg;
        next_bit_cnt = bit_cnt;
        do_load      = 1'b0;
        short_frame  = 1'b0;
        unique case (state)
            ODL_D_IDLE:
            begin
                if (cs_low)
                begin
                    next_state   = ODL_D_SHIFT;
                    next_bit_cnt = '0;
                end
            end
            ODL_D_SHIFT:
            begin
                if (cs_rise)
                begin
                    next_state = ODL_D_IDLE;
                    // Only a complete word may load a register
                    if (bit_cnt >= `ODL_WORD_BITS)
                    begin
                        do_load = 1'b1;
                    end
                    else
                    begin
                        short_frame = 1'b1;
                    end
                end
                else if (sclk_rise)
                begin
                    // Shift left: first bit in ends up at the top, MSB first
                    next_shreg = {shreg[`ODL_WORD_BITS-2:0], filt[`ODL_PIN_SDI]};
                    // Older bits fall off the top, so a 16-bit frame keeps the last 11
                    if (bit_cnt != `ODL_LONG_BITS)
                    begin
                        next_bit_cnt = bit_cnt + 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            state   <= ODL_D_IDLE;
            shreg   <= '0;
            bit_cnt <= '0;
        end
        else
        begin
            state   <= next_state;
            shreg   <= next_shreg;
            bit_cnt <= next_bit_cnt;
        end
    end

    // ==================================================
    // Word decode: address above data
    logic [`ODL_ADDR_W-1:0] rx_addr;
    logic [`ODL_DATA_W-1:0] rx_data;

    assign rx_addr = shreg[`ODL_WORD_BITS-1:`ODL_DATA_W];
    assign rx_data = shreg[`ODL_DATA_W-1:0];

    // ==================================================
    // DAC code registers
    odl_code_t                  dac_reg [0:`ODL_NUM_REGS-1];
    odl_code_t                  next_dac_reg [0:`ODL_NUM_REGS-1];
    logic                       load_ok;
    logic                       load_stb;
    logic [`ODL_ADDR_W-1:0]     load_addr;
    logic                       pd_out;
    logic                       short_out;

    // Loads arriving in power-down are dropped; only a preset still changes codes
    assign load_ok = do_load & ~pd_active;

    generate
        for (gi = 0; gi < `ODL_NUM_REGS; gi++)
        begin : g_reg
            always_comb
            begin
                next_dac_reg[gi] = dac_reg[gi];
                if (pre_active)
                begin
                    next_dac_reg[gi] = `ODL_PRESET_CODE;
                end
                else if (load_ok && (rx_addr == `ODL_ADDR_W'(gi)))
                begin
                    next_dac_reg[gi] = rx_data;
                end
            end

            always_ff @(posedge REF_CLK_I)
            begin
                if (SRST_I)
                begin
                    dac_reg[gi] <= `ODL_PRESET_CODE;
                end
                else
                begin
                    dac_reg[gi] <= next_dac_reg[gi];
                end
            end

            assign CODES_O[gi*`ODL_DATA_W +: `ODL_DATA_W] = dac_reg[gi];
        end
    endgenerate

    // ==================================================
    // Status outputs
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            load_stb  <= 1'b0;
            load_addr <= '0;
            pd_out    <= 1'b0;
            short_out <= 1'b0;
        end
        else
        begin
            load_stb  <= load_ok & ~pre_active;
            load_addr <= load_ok ? rx_addr : load_addr;
            pd_out    <= pd_active;
            short_out <= short_frame;
        end
    end

    assign LOAD_STB_O    = load_stb;
    assign LOAD_ADDR_O   = load_addr;
    assign POWER_DOWN_O  = pd_out;
    assign SHORT_FRAME_O = short_out;

endmodule

// ===== logic/odl_host.sv
// Host end: drives the three-wire frame and the control lines
`timescale 1ns/1ps
`include "odl_consts.svh"

module odl_host
    import odl_pkg::*;
(
    input  wire logic                     REF_CLK_I,
    input  wire logic                     SRST_I,
    odl_if.host                           LNK,
    input  wire logic                     REQ_I,
    input  wire logic [`ODL_ADDR_W-1:0]   ADDR_I,
    input  wire logic [`ODL_DATA_W-1:0]   DATA_I,
    input  wire logic                     LONG_I,
    input  wire logic                     POWER_DOWN_I,
    input  wire logic                     PRESET_I,
    output logic                          BUSY_O,
    output logic                          DONE_O
);

    // ==================================================
    // Frame sequencer
    odl_host_state_e          state;
    odl_host_state_e          next_state;
    logic [`ODL_HALF_W-1:0]   half_cnt;
    logic [`ODL_HALF_W-1:0]   next_half_cnt;
    logic [`ODL_SH_W-1:0]     shreg;
    logic [`ODL_SH_W-1:0]     next_shreg;
    logic [`ODL_CNT_W-1:0]    bits_left;
    logic [`ODL_CNT_W-1:0]    next_bits_left;
    logic                     tick;
    logic                     next_done;
    logic                     cs_n;
    logic                     sclk;
    logic                     sdo;
    logic                     pd_n;
    logic                     pre_n;
    logic                     done;

    // Every phase lasts half a link clock period
    assign tick = (half_cnt == `ODL_HALF_W'(`ODL_SCLK_HALF_CYC - 1));

    always_comb
    begin
        next_state     = state;
        next_shreg     = shreg;
        next_bits_left = bits_left;
        next_done      = 1'b0;
        next_half_cnt  = (state == ODL_H_IDLE || tick) ? '0 : half_cnt + 1'b1;
        unique case (state)
            ODL_H_IDLE:
            begin
                if (REQ_I)
                begin
                    next_state = ODL_H_SELECT;
                    // Long form pads five leading zeros ahead of the word
                    if (LONG_I)
                    begin
                        next_shreg     = {`ODL_PAD_BITS, ADDR_I, DATA_I};
                        next_bits_left = `ODL_LONG_BITS;
                    end
                    else
                    begin
                        next_shreg     = {ADDR_I, DATA_I, `ODL_PAD_BITS};
                        next_bits_left = `ODL_WORD_BITS;
                    end
                end
            end
            ODL_H_SELECT:
            begin
                if (tick)
                begin
                    next_state = ODL_H_LOW;
                end
            end
            ODL_H_LOW:
            begin
                if (tick)
                begin
                    next_state = ODL_H_HIGH;
                end
            end
            ODL_H_HIGH:
            begin
                if (tick)
                begin
                    next_shreg     = {shreg[`ODL_SH_W-2:0], 1'b0};
                    next_bits_left = bits_left - 1'b1;
                    next_state     = (bits_left == `ODL_CNT_W'(1)) ? ODL_H_HOLD : ODL_H_LOW;
                end
            end
            ODL_H_HOLD:
            begin
                // Clock already high; chip select rises only after the last bit
                if (tick)
                begin
                    next_state = ODL_H_GAP;
                    next_done  = 1'b1;
                end
            end
            ODL_H_GAP:
            begin
                // Keeps chip select high long enough for the far filter
                if (tick)
                begin
                    next_state = ODL_H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            state     <= ODL_H_IDLE;
            half_cnt  <= '0;
            shreg     <= '0;
            bits_left <= '0;
            cs_n      <= 1'b1;
            sclk      <= 1'b1;
            sdo       <= 1'b0;
            pd_n      <= 1'b1;
            pre_n     <= 1'b1;
            done      <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            half_cnt  <= next_half_cnt;
            shreg     <= next_shreg;
            bits_left <= next_bits_left;
            cs_n      <= (next_state == ODL_H_IDLE) || (next_state == ODL_H_GAP);
            sclk      <= (next_state != ODL_H_LOW);
            sdo       <= next_shreg[`ODL_SH_W-1];
            pd_n      <= ~POWER_DOWN_I;
            pre_n     <= ~PRESET_I;
            done      <= next_done;
        end
    end

    assign LNK.cs_n         = cs_n;
    assign LNK.sclk         = sclk;
    assign LNK.serial_in    = sdo;
    assign LNK.power_down_n = pd_n;
    assign LNK.preset_n     = pre_n;
    assign BUSY_O           = (state != ODL_H_IDLE);
    assign DONE_O           = done;

endmodule

// ===== verification/odl_checker.sv
// Checker of the frame timing that the host end puts on the serial link
`timescale 1ns/1ps

module odl_checker
(
    input  wire logic REF_CLK_I,
    input  wire logic SRST_I,
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic serial_in,
    input  wire logic power_down_n,
    input  wire logic preset_n
);
    logic       sclk_q;
    logic [4:0] n_fall;
    logic [3:0] hi_run;

    // ==================================================
    // Helper counters
    always_ff @(posedge REF_CLK_I)
    begin
        sclk_q <= sclk;
        n_fall <= (SRST_I || cs_n) ? 5'h00 : n_fall + {4'h0, sclk_q & ~sclk};
        // Saturates so a long idle never wraps back to a legal count
        hi_run <= (SRST_I || !sclk) ? 4'h0 : ((hi_run == 4'hF) ? hi_run : hi_run + 4'h1);
    end

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SRST_I);

    // ==================================================
    // Properties
    property p_cs_edge;
        $changed(cs_n) |-> sclk && $past(sclk);
    endproperty
    a_cs_edge: assert property (p_cs_edge) else $error("cs moved with clock low");

    property p_idle;
        cs_n |-> sclk;
    endproperty
    a_idle: assert property (p_idle) else $error("clock low outside frame");

    property p_select;
        $fell(cs_n) |-> sclk[*4] ##1 !sclk;
    endproperty
    a_select: assert property (p_select) else $error("select lead wrong");

    property p_low_half;
        $fell(sclk) |-> !sclk[*4] ##1 sclk;
    endproperty
    a_low_half: assert property (p_low_half) else $error("low half not 4");

    property p_high_half;
        $rose(sclk) && !cs_n |-> sclk[*4];
    endproperty
    a_high_half: assert property (p_high_half) else $error("high half short");

    property p_data_rise;
        $rose(sclk) |-> $stable(serial_in);
    endproperty
    a_data_rise: assert property (p_data_rise) else $error("data moved at rise");

    property p_bit_count;
        $rose(cs_n) |-> (n_fall == 5'h0B) || (n_fall == 5'h10);
    endproperty
    a_bit_count: assert property (p_bit_count) else $error("bad bit count");

    property p_hold;
        $rose(cs_n) |-> hi_run == 4'h8;
    endproperty
    a_hold: assert property (p_hold) else $error("cs rose early");

    property p_gap;
        $rose(cs_n) |-> cs_n[*5];
    endproperty
    a_gap: assert property (p_gap) else $error("gap too short");

    property p_rst_idle;
        $fell(SRST_I) |-> cs_n && sclk && power_down_n && preset_n;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("lines not idle");

endmodule

// ===== verification/tb_top.sv
// Bench: host and device joined, plus a second device driven raw
`timescale 1ns/1ps
`include "odl_consts.svh"

module tb_top;
    import odl_pkg::*;

    logic        REF_CLK_I = 1'b0;
    logic        SRST_I    = 1'b1;
    logic        req;
    logic        lng;
    logic        pd;
    logic        pre;
    logic [2:0]  addr;
    logic [7:0]  data;
    logic        busy;
    logic        done;
    logic [63:0] codes1;
    logic [63:0] codes2;
    logic        stb1;
    logic        stb2;
    logic        pdo1;
    logic        short2;
    logic [2:0]  la1;
    odl_code_t   exp1 [8];
    odl_code_t   exp2 [8];
    int          err_total = 0;
    int          n_checks  = 0;

    odl_if lnk1 ();
    odl_if lnk2 ();

    odl_host odl_host_inst (.REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .LNK(lnk1.host),
        .REQ_I(req), .ADDR_I(addr), .DATA_I(data), .LONG_I(lng), .POWER_DOWN_I(pd),
        .PRESET_I(pre), .BUSY_O(busy), .DONE_O(done));
    odl_dev odl_dev_inst (.REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .LNK(lnk1.device),
        .CODES_O(codes1), .LOAD_STB_O(stb1), .LOAD_ADDR_O(la1), .POWER_DOWN_O(pdo1),
        .SHORT_FRAME_O());
    odl_dev odl_dev2_inst (.REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .LNK(lnk2.device),
        .CODES_O(codes2), .LOAD_STB_O(stb2), .LOAD_ADDR_O(), .POWER_DOWN_O(),
        .SHORT_FRAME_O(short2));
    odl_checker odl_checker_inst (.REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I),
        .cs_n(lnk1.cs_n), .sclk(lnk1.sclk), .serial_in(lnk1.serial_in),
        .power_down_n(lnk1.power_down_n), .preset_n(lnk1.preset_n));

    always #10 REF_CLK_I = ~REF_CLK_I;

    // ==================================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge REF_CLK_I);
        #1;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic fail(input string msg);
        err_total++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp)
            fail($sformatf("%s got %b exp %b", what, got, exp));
    endtask

    task automatic chk_code(input odl_code_t got, input odl_code_t exp, input string what);
        n_checks++;
        if (got !== exp)
            fail($sformatf("%s got %h exp %h", what, got, exp));
    endtask

    task automatic chk_cnt(input int got, input int exp, input string what);
        n_checks++;
        if (got != exp)
            fail($sformatf("%s got %0d exp %0d", what, got, exp));
    endtask

    // Select lead and final hold each last one half period
    function automatic int done_wait(input logic l);
        return 2 * `ODL_SCLK_HALF_CYC * ((l ? int'(`ODL_LONG_BITS) : int'(`ODL_WORD_BITS)) + 1);
    endfunction

    task automatic chk_all();
        for (int k = 0; k < 8; k++)
        begin
            chk_code(codes1[8*k +: 8], exp1[k], "host side code");
            chk_code(codes2[8*k +: 8], exp2[k], "raw side code");
        end
    endtask

    // Frame keeps a load only when selected and at least a full word long
    function automatic bit loads(input int len, input logic cs_hi);
        return (len >= int'(`ODL_WORD_BITS)) && !cs_hi;
    endfunction

    task automatic wait_stb(input bit raw, output bit got, output bit sh);
        got = 1'b0;
        sh  = 1'b0;
        repeat (12)
        begin
            tick(1);
            if ((raw ? stb2 : stb1) === 1'b1)
                got = 1'b1;
            if (raw && short2 === 1'b1)
                sh = 1'b1;
        end
    endtask

    task automatic host_send(input logic [2:0] a, input odl_code_t d, input logic l);
        int i;
        bit got;
        bit sh;
        i = 0;
        while (busy !== 1'b0 && i < 400)
        begin
            tick(1);
            i++;
        end
        if (i == 400)
        begin
            fail("host stuck busy");
            end_of_test();
        end
        req  = 1'b1;
        addr = a;
        data = d;
        lng  = l;
        tick(1);
        chk_bit(busy, 1'b1, "busy after take");
        req = 1'b0;
        i = 0;
        while (done !== 1'b1 && i < 200)
        begin
            tick(1);
            i++;
        end
        if (i == 200)
        begin
            fail("no done from host");
            end_of_test();
        end
        chk_cnt(i, done_wait(l), "frame length");
        wait_stb(1'b0, got, sh);
        chk_bit(got, !pd, "load strobe");
        if (!pd)
            exp1[a] = d;
        if (got)
            chk_code({5'h00, la1}, {5'h00, a}, "load address");
    endtask

    // Raw frame on the second link; data line flips once released
    task automatic raw_frame(input int n, input logic [15:0] w, input logic cs_hi);
        lnk2.cs_n = cs_hi;
        tick(4);
        for (int i = n - 1; i >= 0; i--)
        begin
            lnk2.sclk      = 1'b0;
            lnk2.serial_in = w[i];
            tick(4);
            lnk2.sclk = 1'b1;
            tick(4);
        end
        tick(4);
        lnk2.cs_n      = 1'b1;
        lnk2.serial_in = ~lnk2.serial_in;
    endtask

    // ==================================================
    // Main sequence
    initial
    begin
        bit          got;
        bit          sh;
        logic [15:0] w;
        int          lens [5];
        logic        cs_hi [5];
        lens  = '{16, 11, 13, 10, 11};
        cs_hi = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        {req, lng, pd, pre, addr, data} = 15'h0000;
        lnk2.cs_n         = 1'b1;
        lnk2.sclk         = 1'b1;
        lnk2.serial_in    = 1'b0;
        lnk2.power_down_n = 1'b1;
        lnk2.preset_n     = 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            exp1[k] = `ODL_PRESET_CODE;
            exp2[k] = `ODL_PRESET_CODE;
        end
        void'($urandom(26));
        tick(16);
        SRST_I = 1'b0;
        tick(6);
        chk_all();
        $display("test reset done");
        for (int a = 0; a < 8; a++)
            host_send(3'(a), a[0] ? 8'hFF : 8'h00, a[1]);
        chk_all();
        $display("test address sweep done");
        repeat (12)
            host_send(3'($urandom), 8'($urandom), 1'($urandom));
        chk_all();
        $display("test random host done");
        for (int i = 0; i < 5; i++)
        begin
            w = 16'($urandom);
            raw_frame(lens[i], w, cs_hi[i]);
            wait_stb(1'b1, got, sh);
            chk_bit(got, loads(lens[i], cs_hi[i]), "raw load");
            chk_bit(sh, !cs_hi[i] && lens[i] < 11, "short frame flag");
            if (got)
                exp2[w[10:8]] = w[7:0];
            chk_all();
        end
        $display("test raw frames done");
        pd = 1'b1;
        tick(10);
        chk_bit(pdo1, 1'b1, "power down seen");
        host_send(3'($urandom), 8'($urandom), 1'b0);
        pd = 1'b0;
        tick(10);
        chk_bit(pdo1, 1'b0, "power down ended");
        chk_all();
        $display("test power down done");
        pre = 1'b1;
        tick(10);
        pre = 1'b0;
        tick(10);
        for (int k = 0; k < 8; k++)
            exp1[k] = `ODL_PRESET_CODE;
        chk_all();
        $display("test preset done");
        end_of_test();
    end

endmodule
